// ===== rtl/tma_defines.svh
// Offsets, field positions, reset values and codes for the transmit address block
`ifndef TMA_DEFINES_SVH
`define TMA_DEFINES_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define TMA_ADDR_WIDTH 16
`define TMA_OFF_ADDR_VALUE 16'h0593
`define TMA_OFF_CHAN_SELECT 16'h0597

// ----------------------------------------
// Field layout and values
// ----------------------------------------
`define TMA_FIELD_MSB 4
`define TMA_FIELD_WIDTH 5
`define TMA_NULL_ADDR 5'h1f
`define TMA_ADDR_RESET 5'h1f
`define TMA_CHAN_RESET 5'h00
`define TMA_CHANNELS 4

`endif

// ===== rtl/tma_pkg.sv
// Types shared by the transmit address block
package tma_pkg;

	// Microprocessor access bundle
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} tma_cpu_req_t;

	// Polling state: idle or driving the cell-available line
	typedef enum logic [1:0] {
		TMA_IDLE = 2'b01,
		TMA_DRIVE = 2'b10
	} tma_poll_t;

endpackage : tma_pkg

// ===== rtl/tma_tx_addr_assign.sv
// Transmit multi-PHY address assignment registers and poll responder
`timescale 1ns/1ps
`include "tma_defines.svh"

module tma_tx_addr_assign
	import tma_pkg::*;
#(
	parameter int NUM_CHANNELS = `TMA_CHANNELS
)
(
	// Clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	// Microprocessor register access, on i_mclk
	input wire tma_cpu_req_t i_cpu,
	output logic [7:0] o_rdata,
	// Mode and per-channel fill state, on i_mclk
	input wire logic i_multi_phy,
	input wire logic [NUM_CHANNELS-1:0] i_chan_space,
	// Cell-interface poll pins, sampled through two flops
	input wire logic [4:0] i_tx_cell_if_addr_bus,
	output logic o_tx_cell_available,
	output logic o_tx_cell_available_oe
);

	// ----------------------------------------
	// Elaboration checks
	// ----------------------------------------
	// Pointer field is five bits wide, so at most 32 channels
	if (NUM_CHANNELS < 1 || NUM_CHANNELS > 32)
	begin : g_bad_channels
		$error("NUM_CHANNELS out of range");
	end

	// ----------------------------------------
	// Reset synchroniser
	// ----------------------------------------
	logic rst_meta_n; // First stage, read only by the second
	logic rst_n; // Released copy used by the rest

	// Assert at once, release after two edges
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			rst_meta_n <= 1'b0;
			rst_n <= 1'b0;
		end
		else
		begin
			rst_meta_n <= 1'b1;
			rst_n <= rst_meta_n;
		end
	end

	// ----------------------------------------
	// Register file
	// ----------------------------------------
	// Index bits that reach every channel; the pointer's upper bits are
	// covered by the range test, so the narrow index never aliases
	localparam int IDX_W = (NUM_CHANNELS > 1) ? $clog2(NUM_CHANNELS) : 1;

	logic [4:0] tx_addr_channel_field; // Assignment pointer
	logic [4:0] chan_addr [NUM_CHANNELS]; // Bound addresses
	logic wr_sel; // Write hits channel-select
	logic wr_addr; // Write hits address value
	logic ptr_ok; // Pointer names an existing channel

	assign wr_sel = i_cpu.wr && (i_cpu.addr == `TMA_OFF_CHAN_SELECT);
	assign wr_addr = i_cpu.wr && (i_cpu.addr == `TMA_OFF_ADDR_VALUE);
	assign ptr_ok = (32'(tx_addr_channel_field) < NUM_CHANNELS);

	// Pointer follows channel-select writes
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			tx_addr_channel_field <= `TMA_CHAN_RESET;
		else if (wr_sel)
			tx_addr_channel_field <= i_cpu.wdata[`TMA_FIELD_MSB:0];
	end

	// Per-channel address store; reset to null so nothing answers early.
	// Only transmit bindings live here, receive addresses are elsewhere.
	for (genvar c = 0; c < NUM_CHANNELS; c++)
	begin : g_chan
		always_ff @(posedge i_mclk or negedge rst_n)
		begin
			if (!rst_n)
				chan_addr[c] <= `TMA_ADDR_RESET;
			else if (wr_addr && tx_addr_channel_field == 5'(c))
				chan_addr[c] <= i_cpu.wdata[`TMA_FIELD_MSB:0];
		end
	end

	// Read data registered; upper bits always zero
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
			o_rdata <= 8'h00;
		else if (i_cpu.rd)
		begin
			case (i_cpu.addr)
				`TMA_OFF_CHAN_SELECT:
					o_rdata <= {3'h0, tx_addr_channel_field};
				`TMA_OFF_ADDR_VALUE:
					// Out-of-range pointer reads back the null address
					o_rdata <= {3'h0, ptr_ok ? chan_addr[tx_addr_channel_field[IDX_W-1:0]]
						: `TMA_NULL_ADDR};
				default:
					o_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------
	// Poll responder
	// ----------------------------------------
	logic [4:0] poll_meta; // First stage only
	logic [4:0] poll_addr; // Synchronised address bus
	logic [NUM_CHANNELS-1:0] hit; // Per-channel match
	tma_poll_t poll_state;

	// Two-flop sampling of the external address bus
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			poll_meta <= `TMA_NULL_ADDR;
			poll_addr <= `TMA_NULL_ADDR;
		end
		else
		begin
			poll_meta <= i_tx_cell_if_addr_bus;
			poll_addr <= poll_meta;
		end
	end

	// Compare against each binding; null never matches
	for (genvar c = 0; c < NUM_CHANNELS; c++)
	begin : g_hit
		assign hit[c] = (poll_addr == chan_addr[c]) && (poll_addr != `TMA_NULL_ADDR);
	end

	// Drive state and level; the line is enabled only by a match in multi-PHY mode
	always_ff @(posedge i_mclk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			poll_state <= TMA_IDLE;
			o_tx_cell_available <= 1'b0;
		end
		else
		begin
			case (poll_state)
				TMA_IDLE, TMA_DRIVE:
				begin
					if (i_multi_phy && |hit)
						poll_state <= TMA_DRIVE;
					else
						poll_state <= TMA_IDLE;
					o_tx_cell_available <= |(hit & i_chan_space);
				end
				default:
					poll_state <= TMA_IDLE;
			endcase
		end
	end

	assign o_tx_cell_available_oe = (poll_state == TMA_DRIVE);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_ptr_follows_write: assert property (@(posedge i_mclk) disable iff (!rst_n)
		wr_sel |=> tx_addr_channel_field == $past(i_cpu.wdata[4:0]))
		else $error("pointer did not follow write");
	a_addr_binds: assert property (@(posedge i_mclk) disable iff (!rst_n)
		wr_addr && tx_addr_channel_field == 5'h0 |=> chan_addr[0] == $past(i_cpu.wdata[4:0]))
		else $error("address not bound to channel");
	a_upper_zero: assert property (@(posedge i_mclk) disable iff (!rst_n)
		o_rdata[7:5] == 3'h0)
		else $error("reserved bits nonzero");
	a_null_silent: assert property (@(posedge i_mclk) disable iff (!rst_n)
		poll_addr == `TMA_NULL_ADDR |=> !o_tx_cell_available_oe)
		else $error("null address drove line");
	a_match_drives: assert property (@(posedge i_mclk) disable iff (!rst_n)
		i_multi_phy && |hit |=> o_tx_cell_available_oe)
		else $error("match did not drive");
	a_nomatch_tri: assert property (@(posedge i_mclk) disable iff (!rst_n)
		!(|hit) |=> !o_tx_cell_available_oe)
		else $error("drove without match");
	a_level_space: assert property (@(posedge i_mclk) disable iff (!rst_n)
		|hit |=> o_tx_cell_available == $past(|(hit & i_chan_space)))
		else $error("wrong fill level");
	a_read_binding: assert property (@(posedge i_mclk) disable iff (!rst_n)
		i_cpu.rd && i_cpu.addr == `TMA_OFF_ADDR_VALUE && tx_addr_channel_field == 5'h0
		|=> o_rdata[4:0] == $past(chan_addr[0]))
		else $error("address read mismatch");

	// Poll answer in two steps: a synchronised match in multi-PHY mode,
	// then one flop later the line is enabled with the fill level
	sequence s_poll_hit;
		i_multi_phy && |hit;
	endsequence
	sequence s_drive_level;
		o_tx_cell_available_oe && (o_tx_cell_available == $past(|(hit & i_chan_space)));
	endsequence
	a_poll_answer: assert property (@(posedge i_mclk) disable iff (!rst_n)
		s_poll_hit |=> s_drive_level)
		else $error("poll answer wrong");
	// Single-PHY mode never drives the shared line
	a_single_quiet: assert property (@(posedge i_mclk) disable iff (!rst_n)
		!i_multi_phy |=> !o_tx_cell_available_oe)
		else $error("drove in single mode");
	// Channel-select read returns the pointer with zero upper bits
	a_sel_read: assert property (@(posedge i_mclk) disable iff (!rst_n)
		i_cpu.rd && !i_cpu.wr && i_cpu.addr == `TMA_OFF_CHAN_SELECT
		|=> o_rdata == {3'h0, $past(tx_addr_channel_field)})
		else $error("select read mismatch");

endmodule : tma_tx_addr_assign

// ===== sim/tma_atm_poller.sv
// Model of the ATM layer processor that polls the cell-available line
`timescale 1ns/1ps
module tma_atm_poller
(
	// Clock
	input wire logic i_mclk,
	// Poll address toward the device
	output logic [4:0] o_poll_addr
);
	// Start on the null address, so no channel answers before the first poll; each poll leaves its address on the bus
	initial o_poll_addr = 5'h1f;
	// Place an address, then wait out the two sync stages and the output flop
	task automatic poll(input logic [4:0] a);
		@(posedge i_mclk);
		#1 o_poll_addr = a;
		repeat (4) @(posedge i_mclk);
		#1;
	endtask : poll
endmodule : tma_atm_poller

// ===== sim/testbench.sv
// Self-checking bench for the transmit address assignment block
`timescale 1ns/1ps
`include "tma_defines.svh"
`define CHK(n, e, g) tests_run++; if ((g) !== (e)) begin $display("unexpected %s exp %h got %h", n, e, g); err_count++; end
module testbench
	import tma_pkg::*;
;
	// ----------------------------------------
	// Signals
	// ----------------------------------------
	logic i_mclk = 1'b0; // System clock
	logic i_rst_n = 1'b0; // Reset, active low
	tma_cpu_req_t cpu = '0; // Register access bundle
	logic multi_phy = 1'b0; // Multi-PHY mode
	logic [3:0] space = 4'h0; // Per-channel room for a cell
	logic [4:0] poll_addr; // Poll address from the model
	logic [7:0] rdata; // Read data
	logic clav; // Cell-available level
	logic clav_oe; // Cell-available enable
	int err_count = 0; // Mismatches
	int tests_run = 0; // Comparisons
	logic [4:0] addrs [4] = '{5'h00, 5'h1e, 5'h05, 5'h0a}; // Both range ends
	always #5 i_mclk = ~i_mclk;
	// ----------------------------------------
	// Instances
	// ----------------------------------------
	tma_tx_addr_assign #(.NUM_CHANNELS(4)) dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
		.i_cpu(cpu), .o_rdata(rdata), .i_multi_phy(multi_phy), .i_chan_space(space),
		.i_tx_cell_if_addr_bus(poll_addr), .o_tx_cell_available(clav),
		.o_tx_cell_available_oe(clav_oe));
	tma_atm_poller atm (.i_mclk(i_mclk), .o_poll_addr(poll_addr));
	// ----------------------------------------
	// Register access tasks
	// ----------------------------------------
	// One-cycle write strobe, launched just after an edge
	task automatic wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge i_mclk);
		#1 cpu = '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
		@(posedge i_mclk);
		#1 cpu.wr = 1'b0;
	endtask : wr
	// Read strobe, data registered at the taking edge and held
	task automatic rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge i_mclk);
		#1 cpu = '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
		@(posedge i_mclk);
		#1 cpu.rd = 1'b0;
		d = rdata;
	endtask : rd
	// Closing report
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask : print_verdict
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial
	begin
		logic [7:0] v;
		repeat (3) @(posedge i_mclk);
		#1 i_rst_n = 1'b1;
		repeat (4) @(posedge i_mclk);
		// Reset state: pointer at zero, nothing bound, line released
		rd(`TMA_OFF_CHAN_SELECT, v); `CHK("sel", 8'h00, v)
		rd(`TMA_OFF_ADDR_VALUE, v); `CHK("addr", 8'h1f, v)
		`CHK("oe", 1'b0, clav_oe)
		$display("test reset done");
		// Select then bind each channel, junk in the read-only bits
		for (int c = 0; c < 4; c++)
		begin
			wr(`TMA_OFF_CHAN_SELECT, 8'he0 | 8'(c));
			wr(`TMA_OFF_ADDR_VALUE, 8'he0 | {3'h0, addrs[c]});
			rd(`TMA_OFF_CHAN_SELECT, v); `CHK("sel", 8'(c), v)
			rd(`TMA_OFF_ADDR_VALUE, v); `CHK("addr", {3'h0, addrs[c]}, v)
		end
		// Pointer past the last channel: write ignored, read gives null
		wr(`TMA_OFF_CHAN_SELECT, 8'h05);
		wr(`TMA_OFF_ADDR_VALUE, 8'h07);
		rd(`TMA_OFF_ADDR_VALUE, v); `CHK("addr oor", 8'h1f, v)
		// Earlier binding survives later ones
		wr(`TMA_OFF_CHAN_SELECT, 8'h02);
		rd(`TMA_OFF_ADDR_VALUE, v); `CHK("addr2", 8'h05, v)
		rd(16'h0590, v); `CHK("unmapped", 8'h00, v)
		$display("test assign done");
		// Poll every channel with mixed room
		multi_phy = 1'b1;
		space = 4'h5;
		for (int c = 0; c < 4; c++)
		begin
			atm.poll(addrs[c]);
			`CHK("oe", 1'b1, clav_oe)
			`CHK("clav", space[c], clav)
		end
		atm.poll(5'h1f); `CHK("oe null", 1'b0, clav_oe)
		atm.poll(5'h11); `CHK("oe miss", 1'b0, clav_oe)
		atm.poll(5'h07); `CHK("oe refused", 1'b0, clav_oe)
		multi_phy = 1'b0;
		atm.poll(addrs[2]); `CHK("oe single", 1'b0, clav_oe)
		$display("test poll done");
		print_verdict();
	end
endmodule : testbench
